// ### rtl/wfm_crc_lane.sv
// One CRC-32 accumulator lane fed only with the bytes its pattern selects.
// Assumes init and feed are qualified by the caller on accepted bytes.
module wfm_crc_lane
    import wfm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        init_i,
    input  wire logic        feed_i,
    input  wire logic [7:0]  byte_i,
    output logic      [31:0] crc_o
);

    typedef struct packed {
        logic [31:0] crc;
    } wfm_lane_s;

    wfm_lane_s st_ff;
    wfm_lane_s nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (init_i)
            nxt_st.crc = WFM_CRC_INIT;
        if (feed_i)
            nxt_st.crc = wfm_crc_step(init_i ? WFM_CRC_INIT : st_ff.crc, byte_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_ff <= '{crc: WFM_CRC_INIT};
        else
            st_ff <= nxt_st;
    end

    // Final complement, as the value stored by software is the transmitted FCS form
    assign crc_o = ~st_ff.crc;

endmodule : wfm_crc_lane

// ### rtl/wfm_pattern_match.sv
// Wake-up frame pattern store and matcher for patterns 1 to 3, Wishbone slave.
// Assumes rx_i is synchronous to clk_i: sof marks the first byte, eof the last.
//
// Summary of operation
// - Select word 0 bit n takes frame byte n+1 (bytes 1 to 16).
// - Select word 1 bit 0 takes byte 17, bit 15 takes byte 32.
// - Select word 2 bit 0 takes byte 33, bit 15 takes byte 48.
// - Select word 3 covers bytes 49 to 64; later bytes never count.
// - Selected bytes feed an IEEE 802.3 CRC-32.
// - Expected sum low register gives CRC bits 15 to 0.
// - Expected sum high register gives CRC bits 31 to 16.
// - Each pattern has its own bank of two sum and four select registers.
// - A pattern is matched only while its detect enable bit is set.
module wfm_pattern_match
    import wfm_pkg::*;
#(
    parameter int NPAT = WFM_NPAT
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire wfm_wb_req_s wb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire wfm_rx_s     rx_i,
    output logic [NPAT-1:0]  wake_o,
    output logic             irq_o
);

    typedef struct packed {
        logic                                    ack;
        logic [31:0]                             dat;
        logic [NPAT-1:0]                         en;
        logic [NPAT-1:0]                         sts;
        logic [NPAT-1:0]                         msk;
        logic                                    irq;
        logic [NPAT-1:0]                         wake;
        logic [NPAT-1:0][31:0]                   sum;
        logic [NPAT-1:0][WFM_NSEL-1:0][WFM_SEL_W-1:0] sel;
        wfm_frame_e                              fr;
        logic [WFM_IDX_W-1:0]                    idx;
        logic                                    check;
    } wfm_state_s;

    wfm_state_s          st_ff;
    wfm_state_s          nxt_st;
    logic [NPAT-1:0]     feed;
    logic                init;
    logic                take;
    logic [WFM_IDX_W-1:0] cur_idx;
    logic [NPAT-1:0][31:0] crc;
    logic [NPAT-1:0]     hit;

    // 16-bit lane merge under byte enables
    function automatic logic [15:0] wfm_merge(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] be);
        return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : wfm_merge

    // True when a frame byte at position ix is selected by the 64-bit mask
    function automatic logic wfm_byte_on(input logic [WFM_NSEL-1:0][WFM_SEL_W-1:0] m,
                                         input logic [WFM_IDX_W-1:0] ix);
        logic [WFM_NSEL*WFM_SEL_W-1:0] flat;
        flat = m;
        if (ix >= WFM_IDX_W'(WFM_FRAME_LIM))
            return 1'b0;
        return flat[ix[5:0]];
    endfunction : wfm_byte_on

    // Byte accepted: first byte of a frame, or any byte while inside one
    assign take    = rx_i.valid && (rx_i.sof || st_ff.fr == FR_RECV);
    assign init    = rx_i.valid && rx_i.sof;
    assign cur_idx = rx_i.sof ? '0 : st_ff.idx;

    generate
        for (genvar p = 0; p < NPAT; p++)
        begin : g_pat
            assign feed[p] = take && wfm_byte_on(st_ff.sel[p], cur_idx);
            // All-zero mask would make every frame hit, so an empty pattern never matches
            assign hit[p]  = st_ff.en[p] && (|st_ff.sel[p])
                             && crc[p] == st_ff.sum[p];

            wfm_crc_lane u_lane (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .init_i (init),
                .feed_i (feed[p]),
                .byte_i (rx_i.data),
                .crc_o  (crc[p])
            );
        end
    endgenerate

    always_comb
    begin
        logic       req;
        logic       wr;
        logic [1:0] bank;
        logic [3:0] ix;
        logic [NPAT-1:0] set;
        logic [NPAT-1:0] clr;
        req  = 1'b0;
        wr   = 1'b0;
        bank = '0;
        ix   = '0;
        set  = '0;
        clr  = '0;
        nxt_st = st_ff;

        req  = wb_i.cyc && wb_i.stb;
        wr   = req && wb_i.we && st_ff.ack;
        bank = wb_i.adr[7:6];
        ix   = wb_i.adr[5:2];

        // Frame tracking: byte position saturates past the selectable window
        nxt_st.check = 1'b0;
        if (take)
        begin
            if (st_ff.idx < WFM_IDX_W'(WFM_FRAME_LIM) || rx_i.sof)
                nxt_st.idx = cur_idx + 1'b1;
            nxt_st.fr = rx_i.eof ? FR_IDLE : FR_RECV;
            nxt_st.check = rx_i.eof;
        end

        // Lanes settle one edge after the last byte, so compare then
        if (st_ff.check)
            set = hit;
        nxt_st.wake = set;

        // Registers: ack one cycle after request, write lands on the ack edge
        nxt_st.ack = req && !st_ff.ack;
        if (req && !st_ff.ack)
        begin
            nxt_st.dat = '0;
            if (bank == WFM_BANK_CTL)
            begin
                case (ix)
                    WFM_IX_EN:  nxt_st.dat[WFM_EN_LSB +: NPAT] = st_ff.en;
                    WFM_IX_STS: nxt_st.dat[WFM_EN_LSB +: NPAT] = st_ff.sts;
                    WFM_IX_MSK: nxt_st.dat[WFM_EN_LSB +: NPAT] = st_ff.msk;
                    default:    nxt_st.dat = '0;
                endcase
            end
            else if (int'(bank) <= NPAT)
            begin
                case (ix)
                    WFM_IX_SUM_LO: nxt_st.dat[15:0] = st_ff.sum[bank-1][15:0];
                    WFM_IX_SUM_HI: nxt_st.dat[15:0] = st_ff.sum[bank-1][31:16];
                    WFM_IX_SEL0:   nxt_st.dat[15:0] = st_ff.sel[bank-1][0];
                    WFM_IX_SEL1:   nxt_st.dat[15:0] = st_ff.sel[bank-1][1];
                    WFM_IX_SEL2:   nxt_st.dat[15:0] = st_ff.sel[bank-1][2];
                    WFM_IX_SEL3:   nxt_st.dat[15:0] = st_ff.sel[bank-1][3];
                    default:       nxt_st.dat = '0;
                endcase
            end
        end

        if (wr)
        begin
            if (bank == WFM_BANK_CTL)
            begin
                case (ix)
                    WFM_IX_EN:  if (wb_i.sel[0]) nxt_st.en  = wb_i.dat[WFM_EN_LSB +: NPAT];
                    WFM_IX_STS: if (wb_i.sel[0]) clr = wb_i.dat[WFM_EN_LSB +: NPAT];
                    WFM_IX_MSK: if (wb_i.sel[0]) nxt_st.msk = wb_i.dat[WFM_EN_LSB +: NPAT];
                    default:    clr = '0;
                endcase
            end
            else if (int'(bank) <= NPAT)
            begin
                case (ix)
                    WFM_IX_SUM_LO: nxt_st.sum[bank-1][15:0] =
                                   wfm_merge(st_ff.sum[bank-1][15:0], wb_i.dat, wb_i.sel);
                    WFM_IX_SUM_HI: nxt_st.sum[bank-1][31:16] =
                                   wfm_merge(st_ff.sum[bank-1][31:16], wb_i.dat, wb_i.sel);
                    WFM_IX_SEL0:   nxt_st.sel[bank-1][0] = wfm_merge(st_ff.sel[bank-1][0], wb_i.dat, wb_i.sel);
                    WFM_IX_SEL1:   nxt_st.sel[bank-1][1] = wfm_merge(st_ff.sel[bank-1][1], wb_i.dat, wb_i.sel);
                    WFM_IX_SEL2:   nxt_st.sel[bank-1][2] = wfm_merge(st_ff.sel[bank-1][2], wb_i.dat, wb_i.sel);
                    WFM_IX_SEL3:   nxt_st.sel[bank-1][3] = wfm_merge(st_ff.sel[bank-1][3], wb_i.dat, wb_i.sel);
                    default:       clr = '0;
                endcase
            end
        end

        // A detection in the clearing cycle survives the clear
        nxt_st.sts = (st_ff.sts & ~clr) | set;
        nxt_st.irq = |(nxt_st.sts & nxt_st.msk);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff       <= '0;
            st_ff.fr    <= FR_IDLE;
            st_ff.sum   <= {(NPAT*2){WFM_REG_RST}};
            st_ff.sel   <= {(NPAT*WFM_NSEL){WFM_REG_RST}};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign wake_o   = st_ff.wake;
    assign irq_o    = st_ff.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_sel_first;
        rx_i.valid && rx_i.sof && st_ff.sel[0][0][0] |-> feed[0];
    endproperty
    a_sel_first: assert property (p_sel_first) else $error("byte 1 not taken by select bit 0");

    property p_sel_second;
        take && !rx_i.sof && st_ff.idx == 7'd16 |-> feed[0] == st_ff.sel[0][1][0];
    endproperty
    a_sel_second: assert property (p_sel_second) else $error("byte 17 not tied to word 1 bit 0");

    property p_sel_third;
        take && !rx_i.sof && st_ff.idx == 7'd47 |-> feed[1] == st_ff.sel[1][2][15];
    endproperty
    a_sel_third: assert property (p_sel_third) else $error("byte 48 not tied to word 2 bit 15");

    property p_sel_limit;
        take && !rx_i.sof && st_ff.idx >= 7'd64 |-> feed == '0;
    endproperty
    a_sel_limit: assert property (p_sel_limit) else $error("byte beyond 64 fed to a lane");

    property p_crc_first;
        feed[0] && init |=> crc[0] == ~wfm_crc_step(WFM_CRC_INIT, $past(rx_i.data));
    endproperty
    a_crc_first: assert property (p_crc_first) else $error("first selected byte gave wrong CRC");

    property p_sum_lo;
        st_ff.ack && wb_i.cyc && wb_i.stb && wb_i.we && wb_i.sel[1:0] == 2'b11
            && wb_i.adr == 8'h40 |=> st_ff.sum[0][15:0] == $past(wb_i.dat[15:0]);
    endproperty
    a_sum_lo: assert property (p_sum_lo) else $error("sum low write lost");

    property p_sum_hi;
        st_ff.ack && wb_i.cyc && wb_i.stb && wb_i.we && wb_i.sel[1:0] == 2'b11
            && wb_i.adr == 8'h88 |=> st_ff.sum[1][31:16] == $past(wb_i.dat[15:0]);
    endproperty
    a_sum_hi: assert property (p_sum_hi) else $error("sum high write lost");

    property p_bank_apart;
        wb_i.adr[7:6] == 2'h1 |=> $stable(st_ff.sum[1]) && $stable(st_ff.sel[2]);
    endproperty
    a_bank_apart: assert property (p_bank_apart) else $error("bank 1 access touched another bank");

    property p_off_quiet;
        st_ff.check && !st_ff.en[0] |=> !wake_o[0];
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("disabled pattern reported");

    property p_hit_seen;
        st_ff.check && hit[2] |=> wake_o[2] && st_ff.sts[2];
    endproperty
    a_hit_seen: assert property (p_hit_seen) else $error("match not recorded");

    property p_irq;
        irq_o == |(st_ff.sts & st_ff.msk);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt disagrees with status and mask");

endmodule : wfm_pattern_match

// ### rtl/wfm_pkg.sv
// Shared constants, carriers and the CRC step for the wake-up pattern matcher.
// Assumes a 32-bit classic Wishbone slave port and a byte-wide receive stream.
package wfm_pkg;

    localparam int          WFM_NPAT     = 3;
    localparam int          WFM_SEL_W    = 16;
    localparam int          WFM_NSEL     = 4;
    localparam int          WFM_FRAME_LIM = 64;
    localparam int          WFM_IDX_W    = 7;

    localparam logic [31:0] WFM_CRC_INIT = 32'hffffffff;
    localparam logic [31:0] WFM_CRC_POLY = 32'hedb88320;
    localparam logic [15:0] WFM_REG_RST  = 16'h0000;

    // Address map: adr[7:6] picks the bank, adr[5:2] is the register index
    localparam logic [1:0]  WFM_BANK_CTL = 2'h0;
    localparam logic [3:0]  WFM_IX_EN    = 4'h0;
    localparam logic [3:0]  WFM_IX_STS   = 4'h1;
    localparam logic [3:0]  WFM_IX_MSK   = 4'h2;
    localparam logic [3:0]  WFM_IX_SUM_LO = 4'h0;
    localparam logic [3:0]  WFM_IX_SUM_HI = 4'h2;
    localparam logic [3:0]  WFM_IX_SEL0  = 4'h4;
    localparam logic [3:0]  WFM_IX_SEL1  = 4'h6;
    localparam logic [3:0]  WFM_IX_SEL2  = 4'h8;
    localparam logic [3:0]  WFM_IX_SEL3  = 4'ha;
    localparam int          WFM_EN_LSB   = 1;

    typedef struct packed {
        logic        valid;
        logic        sof;
        logic        eof;
        logic [7:0]  data;
    } wfm_rx_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wfm_wb_req_s;

    typedef enum {
        FR_IDLE,
        FR_RECV
    } wfm_frame_e;

    // Reflected IEEE 802.3 CRC-32, one byte, LSB first
    function automatic logic [31:0] wfm_crc_step(input logic [31:0] crc, input logic [7:0] b);
        logic [31:0] c;
        c = crc;
        for (int i = 0; i < 8; i++)
        begin
            if (c[0] ^ b[i])
                c = (c >> 1) ^ WFM_CRC_POLY;
            else
                c = c >> 1;
        end
        return c;
    endfunction : wfm_crc_step

endpackage : wfm_pkg

// ### verification/wfm_pattern_match_test.sv
// Self-checking bench for the wake-up pattern matcher with a CRC reference model.
// Assumes the Wishbone map and one-cycle ack described for the matcher.
module wfm_pattern_match_test;
    import wfm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    wfm_wb_req_s wb_i  = '0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    wfm_rx_s     rx_i;
    logic [2:0]  wake_o;
    logic        irq_o;
    int          fail_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          seed = 32'h9f6d47e2;
    int          wcnt[3];
    logic [15:0] msk[1:3][4];
    logic [31:0] sum[1:3];
    logic [7:0]  frm[$];
    logic [31:0] rd;
    logic [3:0]  en;
    logic [3:0]  im;
    logic [2:0]  exp_w;

    wfm_pattern_match #(.NPAT(3)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_i(rx_i), .wake_o(wake_o), .irq_o(irq_o));
    wfm_rx_model rxm (.clk_i(clk_i), .rx_o(rx_i));

    always #10 clk_i = ~clk_i;

    // An unknown on a wake line counts as a pulse so it cannot hide
    always @(posedge clk_i)
    begin
        cycles++;
        for (int b = 0; b < 3; b++)
            if (wake_o[b] !== 1'b0)
                wcnt[b]++;
        if (cycles == 20000)
        begin
            fail_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: a, dat: {16'h0000, d}};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (n == 50)
            fail_count++;
        rd = wb_dat_o;
        wb_i.cyc <= 1'b0;
        wb_i.stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // Register ix of pattern p: 0 sum low, 1 sum high, 2..5 select words
    function automatic logic [15:0] rval(input int p, input int ix);
        if (ix < 2)
            return ix == 0 ? sum[p][15:0] : sum[p][31:16];
        return msk[p][ix - 2];
    endfunction : rval

    function automatic logic [31:0] ref_crc(input int p);
        logic [31:0] c;
        c = WFM_CRC_INIT;
        for (int k = 0; k < frm.size() && k < 64; k++)
            if (msk[p][k / 16][k % 16])
                for (int i = 0; i < 8; i++)
                    c = (c[0] ^ frm[k][i]) ? (c >> 1) ^ WFM_CRC_POLY : c >> 1;
        return ~c;
    endfunction : ref_crc

    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int p = 1; p < 4; p++)
            for (int ix = 0; ix < 6; ix++)
            begin
                wb(1'b0, 8'(64 * p + 8 * ix), 16'h0000);
                chk("reset value", 32'h0, rd);
            end
        for (int a = 0; a < 12; a += 4)
        begin
            wb(1'b0, 8'(a), 16'h0000);
            chk("control reset", 32'h0, rd);
        end
        wb(1'b1, 8'h44, 16'hffff);
        wb(1'b0, 8'h44, 16'h0000);
        chk("unmapped", 32'h0, rd);
        for (int it = 0; it < 12; it++)
        begin
            frm.delete();
            repeat (20 + ($random(seed) & 63)) frm.push_back(8'($random(seed)));
            for (int p = 1; p < 4; p++)
            begin
                for (int w = 0; w < 4; w++)
                    msk[p][w] = (($random(seed) & 3) == 0) ? 16'h0000 : 16'($random(seed));
                // Edge bytes 1 and 64 alone; the frame is 20 to 83 bytes, so bytes beyond 64 that must not count appear only in longer frames
                if (it == 0)
                    msk[p] = '{16'h0001, 16'h0000, 16'h0000, 16'h8000};
                sum[p] = ((it + p) % 3 == 0) ? 32'($random(seed)) : ref_crc(p);
            end
            for (int p = 1; p < 4; p++)
                for (int ix = 0; ix < 6; ix++)
                    wb(1'b1, 8'(64 * p + 8 * ix), rval(p, ix));
            for (int p = 1; p < 4; p++)
                for (int ix = 0; ix < 6; ix++)
                begin
                    wb(1'b0, 8'(64 * p + 8 * ix), 16'h0000);
                    chk("readback", {16'h0000, rval(p, ix)}, rd);
                end
            en = (it == 0) ? 4'he : {3'($random(seed)), 1'b0};
            im = {3'($random(seed)), 1'b0};
            wb(1'b1, 8'h00, {12'h000, en});
            wb(1'b1, 8'h08, {12'h000, im});
            for (int p = 1; p < 4; p++)
                exp_w[p - 1] = en[p] && {msk[p][0], msk[p][1], msk[p][2], msk[p][3]} != 64'h0 && ref_crc(p) == sum[p];
            wcnt = '{0, 0, 0};
            rxm.send(frm, it % 2);
            repeat (5) @(posedge clk_i);
            for (int b = 0; b < 3; b++)
                chk("wake pulses", 32'(exp_w[b]), 32'(wcnt[b]));
            wb(1'b0, 8'h04, 16'h0000);
            chk("status", {28'h0, exp_w, 1'b0}, rd);
            chk("irq", {31'h0, |(exp_w & im[3:1])}, {31'h0, irq_o});
            wb(1'b1, 8'h04, 16'h000e);
            wb(1'b0, 8'h04, 16'h0000);
            chk("status cleared", 32'h0, rd);
            chk("irq cleared", 32'h0, {31'h0, irq_o});
        end
        conclude();
    end
endmodule : wfm_pattern_match_test

// ### verification/wfm_rx_model.sv
// Receive-path stand-in: plays one frame of bytes into the pattern matcher.
// Assumes send is called just after a rising edge of clk_i.
module wfm_rx_model
    import wfm_pkg::*;
(
    input  wire logic clk_i,
    output wfm_rx_s   rx_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial rx_o = '0;

    // Idle data shows the inverse of the last byte so a stale copy is never mistaken for data
    task automatic send(input logic [7:0] f[$], input int gap);
        for (int i = 0; i < f.size(); i++)
        begin
            rx_o <= '{valid: 1'b1, sof: i == 0, eof: i == f.size() - 1, data: f[i]};
            @(posedge clk_i);
            repeat (gap)
            begin
                rx_o <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~f[i]};
                @(posedge clk_i);
            end
        end
        rx_o <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~f[f.size() - 1]};
    endtask : send
endmodule : wfm_rx_model
